// ===== src/tsc_status_counters.sv
/*
 * tsc_status_counters: status flags, interrupt masks and the three
 * per-second error counters of a T1 receiver, behind an APB slave.
 * Assumes all event inputs are one-cycle pulses from framer logic on
 * sys_clk_i, and the sync-lost and alarm inputs are levels on that clock.
 */
`timescale 1ns/1ns

module tsc_status_counters #(
    parameter int unsigned TICK_CYCLES = tsc_pkg::SEC_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // alarm status levels of the first status group
    input wire logic [7:0] alarm_status_i,
    // event pulses for the second status group
    input wire logic rx_multiframe_flag_i,
    input wire logic tx_multiframe_flag_i,
    input wire logic rx_link_buffer_full_i,
    input wire logic tx_link_buffer_empty_i,
    input wire logic rx_link_match_i,
    input wire logic rx_link_abort_i,
    // line and framing error pulses, and the receive sync-lost level
    input wire logic bipolar_violation_i,
    input wire logic zero_sub_codeword_i,
    input wire logic zero_run16_i,
    input wire logic zero_run8_i,
    input wire logic crc6_error_i,
    input wire logic ft_error_i,
    input wire logic fs_error_i,
    input wire logic fps_error_i,
    input wire logic multiframe_oos_i,
    input wire logic rx_sync_lost_i,
    // interrupt outputs and the one-second tick output
    output logic first_interrupt_out_n_o,
    output logic second_interrupt_out_n_o,
    output logic one_second_tick_o
);

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [7:0] alarm_interrupt_mask_reg;
    logic [7:0] event_interrupt_mask_reg;
    logic [7:0] event_status_two_reg;
    logic [7:0] event_status_two_next;
    logic [4:0] count_control_reg;
    logic [31:0] prdata_reg;
    logic [23:0] tick_cnt_reg;
    logic tick_reg;

    // ------------------------------------------------------------------
    // APB decode: access phase always completes in one cycle
    // ------------------------------------------------------------------
    wire logic [5:0] reg_idx = paddr[7:2];
    wire logic setup_ph = psel && !penable;
    wire logic access_ph = psel && penable;
    wire logic wr_acc = access_ph && pwrite;
    wire logic rd_acc = access_ph && !pwrite;

    // true when the index names a register of this block
    function automatic logic idx_mapped(input logic [5:0] idx);
        idx_mapped = (idx == tsc_pkg::IDX_EVENT_STATUS_TWO) ||
                     (idx == tsc_pkg::IDX_LINE_COUNT_HIGH) ||
                     (idx == tsc_pkg::IDX_LINE_COUNT_LOW) ||
                     (idx == tsc_pkg::IDX_PATH_SYNC_SHARED) ||
                     (idx == tsc_pkg::IDX_PATH_COUNT_LOW) ||
                     (idx == tsc_pkg::IDX_SYNC_COUNT_LOW) ||
                     (idx == tsc_pkg::IDX_ALARM_MASK) ||
                     (idx == tsc_pkg::IDX_EVENT_MASK) ||
                     (idx == tsc_pkg::IDX_COUNT_CONTROL);
    endfunction : idx_mapped

    wire logic hit_status2 = reg_idx == tsc_pkg::IDX_EVENT_STATUS_TWO;
    wire logic hit_mask1 = reg_idx == tsc_pkg::IDX_ALARM_MASK;
    wire logic hit_mask2 = reg_idx == tsc_pkg::IDX_EVENT_MASK;
    wire logic hit_ctrl = reg_idx == tsc_pkg::IDX_COUNT_CONTROL;
    wire logic unmapped = !idx_mapped(reg_idx);

    assign pready = 1'b1;
    assign pslverr = access_ph && unmapped;
    assign prdata = prdata_reg;

    // ------------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------------
    wire logic zero_sub_on = count_control_reg[tsc_pkg::BIT_ZERO_SUB];
    wire logic esf_on = count_control_reg[tsc_pkg::BIT_ESF_SELECT];
    wire logic zero_runs_on = count_control_reg[tsc_pkg::BIT_ZERO_RUNS];
    wire logic fs_errs_on = count_control_reg[tsc_pkg::BIT_FS_ERRORS];
    wire logic oos_mode = count_control_reg[tsc_pkg::BIT_SYNC_MODE];

    // ------------------------------------------------------------------
    // one-second timer; the tick steers latching and the status flag
    // ------------------------------------------------------------------
    localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES - 1);
    wire logic tick_wrap = tick_cnt_reg == TICK_LAST;

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tick_cnt_reg <= 24'h000000;
            tick_reg <= 1'b0;
        end else begin
            tick_cnt_reg <= tick_wrap ? 24'h000000 : tick_cnt_reg + 24'h000001;
            tick_reg <= tick_wrap;
        end
    end

    assign one_second_tick_o = tick_reg;

    // ------------------------------------------------------------------
    // counter increment selection
    // ------------------------------------------------------------------
    // a bipolar violation that belongs to a valid substitution word is
    // not a line error; the run length follows the substitution option
    wire logic bpv_counted = bipolar_violation_i &&
                             !(zero_sub_on && zero_sub_codeword_i);
    wire logic zero_run_hit = zero_sub_on ? zero_run8_i : zero_run16_i;
    wire logic line_inc = bpv_counted ||
                          (zero_runs_on && zero_run_hit);

    // path errors: CRC6 in extended mode, Ft (and Fs if asked) in D4
    wire logic path_err = esf_on ? crc6_error_i :
        (ft_error_i || (fs_errs_on && fs_error_i));
    wire logic path_inc = path_err && !rx_sync_lost_i;

    // sync counter: out-of-sync multiframes, or framing pattern errors
    wire logic frame_pat_err = esf_on ? fps_error_i : ft_error_i;
    wire logic sync_inc = oos_mode ? multiframe_oos_i :
                          (frame_pat_err && !rx_sync_lost_i);

    // ------------------------------------------------------------------
    // the three saturating counters, latched together on the tick
    // ------------------------------------------------------------------
    logic [tsc_pkg::LINE_W-1:0] line_violation_counter;
    logic [tsc_pkg::PATH_W-1:0] path_violation_counter;
    logic [tsc_pkg::SYNC_W-1:0] out_of_sync_counter;

    tsc_sat_counter #(.W(tsc_pkg::LINE_W)) u_line_cnt (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .tick_i(tick_reg),
        .inc_i(line_inc),
        .count_o(line_violation_counter)
    );

    tsc_sat_counter #(.W(tsc_pkg::PATH_W)) u_path_cnt (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .tick_i(tick_reg),
        .inc_i(path_inc),
        .count_o(path_violation_counter)
    );

    tsc_sat_counter #(.W(tsc_pkg::SYNC_W)) u_sync_cnt (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .tick_i(tick_reg),
        .inc_i(sync_inc),
        .count_o(out_of_sync_counter)
    );

    // ------------------------------------------------------------------
    // second status flags: sticky, set regardless of mask, cleared by
    // reading; an event in the reading cycle survives the clear
    // ------------------------------------------------------------------
    wire logic [7:0] status2_events = {
        rx_multiframe_flag_i, tx_multiframe_flag_i, tick_reg,
        rx_link_buffer_full_i, tx_link_buffer_empty_i,
        rx_link_match_i, rx_link_abort_i, 1'b0
    };
    wire logic status2_clear = rd_acc && hit_status2;

    // a read clears only the flags it reported: a flag set during the
    // setup cycle missed the read data and must survive the clear
    wire logic [7:0] status2_seen = status2_clear ? prdata_reg[7:0] : 8'h00;

    assign event_status_two_next = status2_events |
        (event_status_two_reg & ~status2_seen);

    // ------------------------------------------------------------------
    // read data mux, sampled in the setup cycle for the access phase
    // ------------------------------------------------------------------
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        unique case (reg_idx)
            tsc_pkg::IDX_EVENT_STATUS_TWO: rd_byte = event_status_two_reg;
            tsc_pkg::IDX_LINE_COUNT_HIGH:
                rd_byte = line_violation_counter[15:8];
            tsc_pkg::IDX_LINE_COUNT_LOW:
                rd_byte = line_violation_counter[7:0];
            tsc_pkg::IDX_PATH_SYNC_SHARED:
                rd_byte = {out_of_sync_counter[11:8],
                    path_violation_counter[11:8]};
            tsc_pkg::IDX_PATH_COUNT_LOW:
                rd_byte = path_violation_counter[7:0];
            tsc_pkg::IDX_SYNC_COUNT_LOW:
                rd_byte = out_of_sync_counter[7:0];
            tsc_pkg::IDX_ALARM_MASK: rd_byte = alarm_interrupt_mask_reg;
            tsc_pkg::IDX_EVENT_MASK: rd_byte = event_interrupt_mask_reg;
            tsc_pkg::IDX_COUNT_CONTROL: rd_byte = {3'h0, count_control_reg};
            default: rd_byte = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------
    // register writes and status update
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            alarm_interrupt_mask_reg <= tsc_pkg::MASK_RESET;
            event_interrupt_mask_reg <= tsc_pkg::MASK_RESET;
            count_control_reg <= tsc_pkg::CONTROL_RESET;
            event_status_two_reg <= tsc_pkg::STATUS_RESET;
            prdata_reg <= 32'h00000000;
        end else begin
            event_status_two_reg <= event_status_two_next;
            if (setup_ph) begin
                prdata_reg <= {24'h000000, rd_byte};
            end
            if (wr_acc && hit_mask1) begin
                alarm_interrupt_mask_reg <= pwdata[7:0];
            end
            if (wr_acc && hit_mask2) begin
                // the unassigned low bit is kept at zero
                event_interrupt_mask_reg <= {pwdata[7:1], 1'b0};
            end
            if (wr_acc && hit_ctrl) begin
                count_control_reg <= pwdata[4:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // interrupt outputs, active low, only enabled sources pull them down
    // ------------------------------------------------------------------
    wire logic alarm_pending = |(alarm_status_i & alarm_interrupt_mask_reg);
    wire logic event_pending =
        |(event_status_two_reg[7:1] & event_interrupt_mask_reg[7:1]);

    assign first_interrupt_out_n_o = !alarm_pending;
    assign second_interrupt_out_n_o = !event_pending;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    chk_second_interrupt_out_pending: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        (rx_link_buffer_full_i &&
         event_interrupt_mask_reg[tsc_pkg::BIT_RX_LINK_FULL])
        |=> !second_interrupt_out_n_o)
        else $error("enabled link full did not assert interrupt");

    chk_flag_unmasked: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        rx_link_abort_i |=> event_status_two_reg[tsc_pkg::BIT_RX_LINK_ABORT])
        else $error("event flag not set while masked");

    chk_masked_quiet: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        (alarm_interrupt_mask_reg == 8'h00) |-> first_interrupt_out_n_o)
        else $error("alarm interrupt asserted while all masked");

    chk_sec_flag: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        tick_reg |=> event_status_two_reg[tsc_pkg::BIT_ONE_SECOND])
        else $error("one-second flag not set on tick");

    chk_path_halt: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i) rx_sync_lost_i |-> !path_inc)
        else $error("path counter incremented while unsynced");

    chk_line_unsynced: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        (rx_sync_lost_i && bipolar_violation_i && !zero_sub_on) |-> line_inc)
        else $error("line counter stopped while unsynced");

    chk_oos_mode: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        (oos_mode && multiframe_oos_i) |-> sync_inc)
        else $error("out-of-sync multiframe not counted");

    chk_mask2_low: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        (wr_acc && hit_mask2) |=>
        event_interrupt_mask_reg == {$past(pwdata[7:1]), 1'b0})
        else $error("event mask write not stored");

    chk_apb_unmapped: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i) (access_ph && unmapped) |->
        (pslverr && prdata == 32'h00000000))
        else $error("unmapped access without error or with data");

    chk_tick_spacing: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i) tick_reg |=> !tick_reg)
        else $error("tick longer than one cycle");

    chk_flag_kept: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        (status2_clear && event_status_two_reg[tsc_pkg::BIT_RX_LINK_ABORT] &&
         !prdata_reg[tsc_pkg::BIT_RX_LINK_ABORT]) |=>
        event_status_two_reg[tsc_pkg::BIT_RX_LINK_ABORT])
        else $error("unreported flag lost by status read");

    chk_status_clear: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        (status2_clear && prdata_reg[tsc_pkg::BIT_RX_LINK_ABORT] &&
         !rx_link_abort_i) |=>
        !event_status_two_reg[tsc_pkg::BIT_RX_LINK_ABORT])
        else $error("reported flag not cleared by status read");

    chk_mask1_write: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        (wr_acc && hit_mask1) |=>
        alarm_interrupt_mask_reg == $past(pwdata[7:0]))
        else $error("alarm mask write not stored");

    chk_sync_halt: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i) (!oos_mode && rx_sync_lost_i) |-> !sync_inc)
        else $error("sync counter counted pattern errors unsynced");

    chk_second_interrupt_out_quiet: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        (event_interrupt_mask_reg == 8'h00) |-> second_interrupt_out_n_o)
        else $error("event interrupt asserted while all masked");

endmodule : tsc_status_counters

// ===== src/tsc_pkg.sv
/*
 * tsc_pkg: shared constants of the T1 status, mask and error counter bank.
 * Assumes a 10 MHz system clock and an APB master with 32-bit data.
 */
package tsc_pkg;

    // ------------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [5:0] IDX_EVENT_STATUS_TWO = 6'h21;
    localparam logic [5:0] IDX_LINE_COUNT_HIGH = 6'h23;
    localparam logic [5:0] IDX_LINE_COUNT_LOW = 6'h24;
    localparam logic [5:0] IDX_PATH_SYNC_SHARED = 6'h25;
    localparam logic [5:0] IDX_PATH_COUNT_LOW = 6'h26;
    localparam logic [5:0] IDX_SYNC_COUNT_LOW = 6'h27;
    localparam logic [5:0] IDX_ALARM_MASK = 6'h16;
    localparam logic [5:0] IDX_EVENT_MASK = 6'h17;
    localparam logic [5:0] IDX_COUNT_CONTROL = 6'h2C;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int BIT_RX_MULTIFRAME = 7;
    localparam int BIT_TX_MULTIFRAME = 6;
    localparam int BIT_ONE_SECOND = 5;
    localparam int BIT_RX_LINK_FULL = 4;
    localparam int BIT_TX_LINK_EMPTY = 3;
    localparam int BIT_RX_LINK_MATCH = 2;
    localparam int BIT_RX_LINK_ABORT = 1;
    // count control register fields
    localparam int BIT_ZERO_SUB = 0;
    localparam int BIT_ESF_SELECT = 1;
    localparam int BIT_ZERO_RUNS = 2;
    localparam int BIT_FS_ERRORS = 3;
    localparam int BIT_SYNC_MODE = 4;

    // ------------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------------
    localparam int LINE_W = 16;
    localparam int PATH_W = 12;
    localparam int SYNC_W = 12;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [4:0] CONTROL_RESET = 5'h00;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int ONE_SECOND_NS = 1000000000;
    localparam int SEC_CYCLES = ONE_SECOND_NS / CLK_PERIOD_NS;

endpackage : tsc_pkg

// ===== src/tsc_sat_counter.sv
/*
 * tsc_sat_counter: saturating event counter with a latch loaded on a tick.
 * Assumes inc_i and tick_i are one-cycle pulses on sys_clk_i.
 */
`timescale 1ns/1ns
module tsc_sat_counter #(
    parameter int W = 16
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic tick_i,
    input wire logic inc_i,
    output logic [W-1:0] count_o
);

    logic [W-1:0] run_reg;
    logic [W-1:0] run_next;
    logic [W-1:0] latch_reg;
    wire logic at_max = &run_reg;

    // --------------------------------------------------------------
    // running count; an event on the tick starts the new second at one
    // --------------------------------------------------------------
    assign run_next = tick_i ? {{(W-1){1'b0}}, inc_i} :
                      (inc_i && !at_max) ? run_reg + 1'b1 : run_reg;

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            run_reg <= '0;
            latch_reg <= '0;
        end else begin
            run_reg <= run_next;
            if (tick_i) begin
                latch_reg <= run_reg;
            end
        end
    end

    assign count_o = latch_reg;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    chk_cnt_saturate: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i) (at_max && !tick_i) |=> (&run_reg))
        else $error("counter left its maximum without a tick");
    chk_cnt_latch: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i) tick_i |=> count_o == $past(run_reg))
        else $error("latched count differs from last second");

endmodule : tsc_sat_counter

// ===== tb/tsc_host_model.sv
/* tsc_host_model: APB master standing in for the host controller.
   Assumes one clock and a slave that may insert wait states. */
`timescale 1ns/1ns
module tsc_host_model (
    input wire logic sys_clk_i,
    input wire logic [31:0] prdata_i,
    input wire logic pready_i,
    input wire logic pslverr_i,
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [7:0] paddr_o,
    output logic [31:0] pwdata_o,
    output logic [32:0] rd_data_o,
    output int rd_seq_o
);
    // idle bus at time zero
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 8'h00;
        pwdata_o = 32'h0000_0000;
        rd_data_o = 33'h0_0000_0000;
        rd_seq_o = 0;
    end
    // one transfer; address and data go inverted once released so a
    // stale value can never pass for a live one
    task automatic xfer(input logic wr, input logic [5:0] idx,
            input logic [7:0] d);
        @(posedge sys_clk_i);
        psel_o <= 1'b1;
        penable_o <= 1'b0;
        pwrite_o <= wr;
        paddr_o <= {idx, 2'b00};
        pwdata_o <= {24'h00_0000, d[7:1],
            d[0] & (idx != tsc_pkg::IDX_EVENT_MASK)};
        @(posedge sys_clk_i);
        penable_o <= 1'b1;
        do @(posedge sys_clk_i); while (pready_i !== 1'b1);
        if (!wr) begin
            rd_data_o <= {pslverr_i, prdata_i};
            rd_seq_o <= rd_seq_o + 1;
        end
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        paddr_o <= ~paddr_o;
        pwdata_o <= ~pwdata_o;
    endtask : xfer
endmodule : tsc_host_model

// ===== tb/tsc_status_counters_tb.sv
/* tsc_status_counters_tb: self-checking bench of the status, mask and
   error counter bank. Assumes the one-second period is shortened. */
`timescale 1ns/1ns
module tsc_status_counters_tb;
    localparam int TICKS = 4200;
    logic sys_clk, rstn, lost, l, psel, penable, pwrite, pready, pslverr;
    logic int1_n, second_interrupt_out_n, tick, li, pi, si;
    logic [7:0] alarm, ev, paddr, m, a;
    logic [8:0] err, e;
    logic [31:0] pwdata, prdata;
    logic [32:0] rd_data, c, ones = {33{1'b1}};
    logic [32:0] q_exp[$];
    logic [32:0] q_care[$];
    logic [15:0] n_line;
    logic [11:0] n_path, n_sync;
    logic [4:0] cfg;
    logic [4:0] cfgs[5] = '{5'h05, 5'h06, 5'h1A, 5'h09, 5'h10};
    int evb[6] = '{7, 6, 4, 3, 2, 1};
    int rd_seq, seen = 0, fails = 0, num_checks = 0, cyc = 0, b;
    time t0;

    tsc_status_counters #(.TICK_CYCLES(TICKS)) tsc_status_counters_i (
        .sys_clk_i(sys_clk), .rstn_i(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .alarm_status_i(alarm),
        .rx_multiframe_flag_i(ev[7]), .tx_multiframe_flag_i(ev[6]),
        .rx_link_buffer_full_i(ev[4]), .tx_link_buffer_empty_i(ev[3]),
        .rx_link_match_i(ev[2]), .rx_link_abort_i(ev[1]),
        .bipolar_violation_i(err[0]), .zero_sub_codeword_i(err[1]),
        .zero_run16_i(err[2]), .zero_run8_i(err[3]),
        .crc6_error_i(err[4]), .ft_error_i(err[5]), .fs_error_i(err[6]),
        .fps_error_i(err[7]), .multiframe_oos_i(err[8]),
        .rx_sync_lost_i(lost), .first_interrupt_out_n_o(int1_n),
        .second_interrupt_out_n_o(second_interrupt_out_n), .one_second_tick_o(tick));
    tsc_host_model tsc_host_model_i (.sys_clk_i(sys_clk),
        .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr),
        .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
        .paddr_o(paddr), .pwdata_o(pwdata), .rd_data_o(rd_data),
        .rd_seq_o(rd_seq));

    // ----------------------------------------------------------------
    // checking and closing
    // ----------------------------------------------------------------
    task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : cmp
    task automatic end_sim;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic rd(input logic [5:0] idx, input logic [32:0] exp,
            input logic [32:0] care);
        q_exp.push_back(exp & care);
        q_care.push_back(care);
        tsc_host_model_i.xfer(1'b0, idx, 8'h00);
    endtask : rd
    task automatic pulse(input int bit_no);
        @(posedge sys_clk);
        ev <= 8'h01 << bit_no;
        @(posedge sys_clk);
        ev <= 8'h00;
        @(negedge sys_clk);
    endtask : pulse
    task automatic wait_tick;
        do @(posedge sys_clk); while (tick !== 1'b1);
    endtask : wait_tick

    // read results are compared oldest note first, the moment they land
    always @(posedge sys_clk) begin
        if (rd_seq != seen) begin
            seen = rd_seq;
            c = q_care.pop_front();
            cmp(rd_data & c, q_exp.pop_front());
        end
    end
    // hang guard: the planned run is near 50400 cycles
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 62000) begin
            fails++;
            end_sim();
        end
    end
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    initial begin
        rstn = 1'b0; alarm = 8'h00; ev = 8'h00; err = 9'h000; lost = 1'b0;
        void'($urandom(99016));
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        rd(tsc_pkg::IDX_ALARM_MASK, 33'h0_0000_0000, ones);
        rd(tsc_pkg::IDX_EVENT_MASK, 33'h0_0000_0000, ones);
        rd(6'h3F, 33'h1_0000_0000, ones);
        // each alarm bit alone, then random mask and alarm mixes
        for (int i = 0; i < 12; i++) begin
            m = (i < 8) ? 8'h01 << i : 8'($urandom);
            a = (i < 8) ? m : 8'($urandom);
            tsc_host_model_i.xfer(1'b1, tsc_pkg::IDX_ALARM_MASK, m);
            alarm <= a;
            @(negedge sys_clk);
            cmp({32'h0, int1_n}, {32'h0, ~|(a & m)});
            @(posedge sys_clk);
            alarm <= ~a;
            @(negedge sys_clk);
            cmp({32'h0, int1_n}, {32'h0, ~|(~a & m)});
        end
        rd(tsc_pkg::IDX_ALARM_MASK, {25'h0, m}, ones);
        tsc_host_model_i.xfer(1'b1, tsc_pkg::IDX_EVENT_MASK, 8'hFF);
        rd(tsc_pkg::IDX_EVENT_MASK, 33'h0_0000_00FE, ones);
        // each event flag: masked, then enabled, cleared by a read
        foreach (evb[j]) begin
            b = evb[j];
            tsc_host_model_i.xfer(1'b1, tsc_pkg::IDX_EVENT_MASK, 8'h00);
            pulse(b);
            cmp({32'h0, second_interrupt_out_n}, 33'h0_0000_0001);
            rd(tsc_pkg::IDX_EVENT_STATUS_TWO, ones, 33'h1 << b);
            rd(tsc_pkg::IDX_EVENT_STATUS_TWO, 33'h0, 33'h1 << b);
            // event lands in the setup cycle of a status read: not reported
            // by that read, so it must still be pending for the next one
            fork
                rd(tsc_pkg::IDX_EVENT_STATUS_TWO, 33'h0, 33'h1 << b);
                pulse(b);
            join
            rd(tsc_pkg::IDX_EVENT_STATUS_TWO, ones, 33'h1 << b);
            tsc_host_model_i.xfer(1'b1, tsc_pkg::IDX_EVENT_MASK, 8'h01 << b);
            pulse(b);
            cmp({32'h0, second_interrupt_out_n}, 33'h0_0000_0000);
            rd(tsc_pkg::IDX_EVENT_STATUS_TWO, ones, 33'h1 << b);
            @(negedge sys_clk);
            cmp({32'h0, second_interrupt_out_n}, 33'h0_0000_0001);
        end
        // one counting second per mode mix, the last one saturating the path and sync counters
        for (int p = 0; p < 6; p++) begin
            cfg = (p < 5) ? cfgs[p] : 5'h12;
            tsc_host_model_i.xfer(1'b1, tsc_pkg::IDX_COUNT_CONTROL,
                {3'h0, cfg});
            wait_tick();
            t0 = $time;
            n_line = 16'h0000;
            n_path = 12'h000;
            n_sync = 12'h000;
            repeat ((p < 5) ? 300 : 4150) begin
                b = $urandom_range(9, 0);
                e = (b == 0) ? 9'h000 : (b == 1) ? 9'h001 :
                    (b == 2) ? 9'h003 : 9'h001 << (b - 1);
                l = ($urandom_range(3, 0) == 0);
                if (p == 5) begin
                    e = 9'h1FF;
                    l = 1'b0;
                end
                li = (e[0] && !(cfg[0] && e[1])) ||
                     (cfg[2] && (cfg[0] ? e[3] : e[2]));
                pi = !l && (cfg[1] ? e[4] : (e[5] || (cfg[3] && e[6])));
                si = cfg[4] ? e[8] : (!l && (cfg[1] ? e[7] : e[5]));
                if (li && n_line != 16'hFFFF) n_line++;
                if (pi && n_path != 12'hFFF) n_path++;
                if (si && n_sync != 12'hFFF) n_sync++;
                @(posedge sys_clk);
                err <= e;
                lost <= l;
            end
            @(posedge sys_clk);
            err <= 9'h000;
            lost <= 1'b0;
            wait_tick();
            cmp(33'(($time - t0) / tsc_pkg::CLK_PERIOD_NS), 33'(TICKS));
            // host fetches within the second that follows the tick
            rd(tsc_pkg::IDX_LINE_COUNT_HIGH,
                {25'h0, n_line[15:8]}, ones);
            rd(tsc_pkg::IDX_LINE_COUNT_LOW,
                {25'h0, n_line[7:0]}, ones);
            rd(tsc_pkg::IDX_PATH_SYNC_SHARED,
                {25'h0, n_sync[11:8], n_path[11:8]}, ones);
            rd(tsc_pkg::IDX_PATH_COUNT_LOW,
                {25'h0, n_path[7:0]}, ones);
            rd(tsc_pkg::IDX_SYNC_COUNT_LOW,
                {25'h0, n_sync[7:0]}, ones);
            rd(tsc_pkg::IDX_EVENT_STATUS_TWO, ones, 33'h20);
        end
        repeat (4) @(posedge sys_clk);
        end_sim();
    end
endmodule : tsc_status_counters_tb
